/* rtl/usf_flags.sv */
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "usf_consts.svh"
module usf_flags
   import usf_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`USF_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_rx_line_i,
   input wire logic sample_en_i,
   input wire logic rx_done_i,
   input wire logic [`USF_DATA_W-1:0] rx_data_i,
   input wire logic rx_parity_bad_i,
   input wire logic tx_done_i,
   output logic tx_start_o,
   output logic [`USF_DATA_W-1:0] tx_word_o,
   output logic rx_irq_request_o,
   output logic tx_irq_request_o,
   output logic irq_o,
   output logic [5:0] serial_status_reg_o
);
   // ================================================
   // Voted line level
   logic voted_bit;

   usf_vote u_vote (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .sample_en_i(sample_en_i),
      .serial_rx_line_i(serial_rx_line_i),
      .bit_o(voted_bit)
   );

   // ================================================
   // State and decoded strobes
   usf_state_type st_r;
   usf_state_type st_nxt;
   logic access;
   logic wr;
   logic rd;
   logic rd_status;
   logic rd_rxbuf;
   logic wr_txbuf;
   logic wr_irq_clr;
   logic wr_irq_en;
   logic addr_mapped;
   logic [31:0] rd_word;
   logic [`USF_STAT_W-1:0] stat;
   logic [`USF_ARM_W-1:0] rx_flags;
   logic [`USF_ARM_W-1:0] clr_mask;
   logic [`USF_ARM_W-1:0] arm_nxt;
   logic rx_keep;
   logic rx_overrun;
   logic rx_drop;
   logic rx_evt;
   logic tx_move;
   logic tx_finish;
   logic tx_evt;
   genvar gi;

   // ================================================
   // Bus decode: every effect lands at the taking edge only
   assign access = psel && penable && !st_r.pready;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   assign rd_status = rd && (paddr == `USF_ADDR_STATUS);
   assign rd_rxbuf = rd && (paddr == `USF_ADDR_RXBUF);
   assign wr_txbuf = wr && (paddr == `USF_ADDR_TXBUF);
   assign wr_irq_clr = wr && (paddr == `USF_ADDR_IRQ_CLR);
   assign wr_irq_en = wr && (paddr == `USF_ADDR_IRQ_EN);

   always_comb begin
      case (paddr)
         `USF_ADDR_STATUS,
         `USF_ADDR_RXBUF,
         `USF_ADDR_TXBUF,
         `USF_ADDR_IRQ_STAT,
         `USF_ADDR_IRQ_CLR,
         `USF_ADDR_IRQ_EN: begin
            addr_mapped = 1'b1;
         end
         default: begin
            addr_mapped = 1'b0;
         end
      endcase
   end

   // ================================================
   // Status vector
   always_comb begin
      stat = '0;
      stat[`USF_ST_PERR] = st_r.perr;
      stat[`USF_ST_FERR] = st_r.ferr;
      stat[`USF_ST_OVERRUN] = st_r.overrun_flag;
      stat[`USF_ST_RX_FULL] = st_r.rx_holding_full_flag;
      stat[`USF_ST_TX_ACTIVE] = st_r.tx_active_flag;
      stat[`USF_ST_TX_FULL] = st_r.tx_holding_full_flag;
   end

   // Clearable flags share the low status positions with the armed bits
   assign rx_flags = stat[`USF_ARM_W-1:0];

   // ================================================
   // Per-flag arming: capture on a status read, drop on a buffer read
   generate
      for (gi = 0; gi < `USF_ARM_W; gi = gi + 1) begin : g_arm
         assign clr_mask[gi] = rd_rxbuf && st_r.armed[gi];
         assign arm_nxt[gi] = rd_status ? rx_flags[gi] :
                              (rd_rxbuf ? 1'b0 : st_r.armed[gi]);
      end
   endgenerate

   // ================================================
   // Receive events
   // While overrun stands every word is thrown away unseen
   assign rx_drop = rx_done_i && st_r.overrun_flag;
   assign rx_overrun = rx_done_i && !st_r.overrun_flag &&
                       st_r.rx_holding_full_flag;
   assign rx_keep = rx_done_i && !st_r.overrun_flag &&
                    !st_r.rx_holding_full_flag;
   assign rx_evt = rx_overrun || rx_keep;

   // ================================================
   // Transmit events
   assign tx_move = st_r.tx_holding_full_flag &&
                    (!st_r.tx_active_flag || tx_done_i);
   assign tx_finish = tx_done_i && !st_r.tx_holding_full_flag;
   assign tx_evt = tx_move;

   // ================================================
   // Read data
   always_comb begin
      rd_word = '0;
      case (paddr)
         `USF_ADDR_STATUS: begin
            rd_word[`USF_STAT_W-1:0] = stat;
         end
         `USF_ADDR_RXBUF: begin
            rd_word[`USF_DATA_W-1:0] = st_r.rx_holding_buffer;
         end
         `USF_ADDR_IRQ_STAT: begin
            rd_word[`USF_IRQ_W-1:0] = st_r.irq_stat;
         end
         `USF_ADDR_IRQ_EN: begin
            rd_word[`USF_IRQ_W-1:0] = st_r.irq_en;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // ================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.tx_start = 1'b0;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      // Buffer read clears only the flags the last status read saw
      if (clr_mask[`USF_ST_PERR]) begin
         st_nxt.perr = 1'b0;
      end
      if (clr_mask[`USF_ST_FERR]) begin
         st_nxt.ferr = 1'b0;
      end
      if (clr_mask[`USF_ST_OVERRUN]) begin
         st_nxt.overrun_flag = 1'b0;
      end
      if (clr_mask[`USF_ST_RX_FULL]) begin
         st_nxt.rx_holding_full_flag = 1'b0;
      end
      st_nxt.armed = arm_nxt;
      // Received word; sets follow clears so they win
      if (rx_overrun) begin
         st_nxt.overrun_flag = 1'b1;
      end
      if (rx_keep) begin
         st_nxt.rx_holding_buffer = rx_data_i;
         st_nxt.rx_holding_full_flag = 1'b1;
         // Error flags only ever describe a kept word
         if (rx_parity_bad_i) begin
            st_nxt.perr = 1'b1;
         end
         if (!voted_bit) begin
            st_nxt.ferr = 1'b1;
         end
      end
      // Holding word moves to the shifter when idle or on completion
      if (tx_move) begin
         st_nxt.tx_start = 1'b1;
         st_nxt.tx_word = st_r.tx_holding_buffer;
         st_nxt.tx_holding_full_flag = 1'b0;
         st_nxt.tx_active_flag = 1'b1;
      end else if (tx_finish) begin
         st_nxt.tx_active_flag = 1'b0;
      end
      // A write in the cycle of a move refills the holding buffer
      if (wr_txbuf) begin
         st_nxt.tx_holding_buffer = pwdata[`USF_DATA_W-1:0];
         st_nxt.tx_holding_full_flag = 1'b1;
      end
      st_nxt.rx_irq_request = rx_evt;
      st_nxt.tx_irq_request = tx_evt;
      // Interrupt status: a new event beats a clear in the same cycle
      if (wr_irq_clr) begin
         st_nxt.irq_stat = st_r.irq_stat & ~pwdata[`USF_IRQ_W-1:0];
      end
      if (wr_irq_en) begin
         st_nxt.irq_en = pwdata[`USF_IRQ_W-1:0];
      end
      if (rx_evt) begin
         st_nxt.irq_stat[`USF_IRQ_RX] = 1'b1;
      end
      if (tx_evt) begin
         st_nxt.irq_stat[`USF_IRQ_TX] = 1'b1;
      end
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);
      // APB answer one cycle into the access phase
      if (access) begin
         st_nxt.pready = 1'b1;
         st_nxt.pslverr = !addr_mapped;
         st_nxt.prdata = rd ? rd_word : '0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign tx_start_o = st_r.tx_start;
   assign tx_word_o = st_r.tx_word;
   assign rx_irq_request_o = st_r.rx_irq_request;
   assign tx_irq_request_o = st_r.tx_irq_request;
   assign irq_o = st_r.irq;
   assign serial_status_reg_o = stat;
endmodule // usf_flags
`default_nettype wire

/* common/usf_consts.svh */
`ifndef USF_CONSTS_SVH
`define USF_CONSTS_SVH
// Contract
// - Low stop sample sets framing flag, rx irq
// - Framing flag clears only if read armed
// - Word during full buffer: overrun, discard
// - While overrun set, drop words silently
// - Dropped words never set error flags
// - Overrun flag clears only if read armed
// - Buffer load sets rx full flag
// - Rx full flag clears only if armed
// - Tx done with empty holding clears busy
// - Restart after write sets busy, tx irq
// - Holding moves to shifter: clear full, irq
// - Holding write sets tx full flag
// - No count of lost words kept
// - Parity mismatch sets parity flag, rx irq
// - Bits decided by two-of-three majority
// ================================================
// Register offsets (byte addresses)
`define USF_ADDR_STATUS 12'h000
`define USF_ADDR_RXBUF 12'h004
`define USF_ADDR_TXBUF 12'h008
`define USF_ADDR_IRQ_STAT 12'h00C
`define USF_ADDR_IRQ_CLR 12'h010
`define USF_ADDR_IRQ_EN 12'h014
// ================================================
// Status bit positions
`define USF_ST_PERR 0
`define USF_ST_FERR 1
`define USF_ST_OVERRUN 2
`define USF_ST_RX_FULL 3
`define USF_ST_TX_ACTIVE 4
`define USF_ST_TX_FULL 5
`define USF_STAT_W 6
// Interrupt status bits
`define USF_IRQ_RX 0
`define USF_IRQ_TX 1
`define USF_IRQ_W 2
`define USF_DATA_W 8
`define USF_ARM_W 4
`define USF_ADDR_W 12
`endif

/* common/usf_pkg.sv */
package usf_pkg;
   `include "usf_consts.svh"

   typedef struct packed {
      logic [`USF_ARM_W-1:0] armed;
      logic perr;
      logic ferr;
      logic overrun_flag;
      logic rx_holding_full_flag;
      logic tx_active_flag;
      logic tx_holding_full_flag;
      logic [`USF_DATA_W-1:0] rx_holding_buffer;
      logic [`USF_DATA_W-1:0] tx_holding_buffer;
      logic [`USF_IRQ_W-1:0] irq_stat;
      logic [`USF_IRQ_W-1:0] irq_en;
      logic rx_irq_request;
      logic tx_irq_request;
      logic tx_start;
      logic [`USF_DATA_W-1:0] tx_word;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } usf_state_type;

   typedef struct packed {
      logic done;
      logic [`USF_DATA_W-1:0] data;
      logic parity_bad;
      logic stop_bit;
   } usf_rx_word_type;

   typedef struct packed {
      logic [2:0] samples;
   } usf_vote_type;
endpackage

/* rtl/usf_vote.sv */
`timescale 1ns/10ps
`default_nettype none
module usf_vote
   import usf_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic sample_en_i,
   input wire logic serial_rx_line_i,
   output logic bit_o
);
   // ================================================
   // Majority of the last three samples
   logic [2:0] sync_r;
   usf_vote_type vote_r;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync_r <= 3'h7;
         vote_r <= '1;
      end else begin
         sync_r <= {sync_r[1:0], serial_rx_line_i};
         if (sample_en_i && (sync_r[1] == sync_r[2])) begin
            vote_r.samples <= {vote_r.samples[1:0], sync_r[2]};
         end
      end
   end

   assign bit_o = (vote_r.samples[0] & vote_r.samples[1]) |
                  (vote_r.samples[1] & vote_r.samples[2]) |
                  (vote_r.samples[0] & vote_r.samples[2]);
endmodule // usf_vote
`default_nettype wire

/* dv/usf_flags_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "usf_consts.svh"
module usf_flags_checker
   import usf_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`USF_ADDR_W-1:0] paddr,
   input wire logic pready,
   input wire logic rx_done_i,
   input wire logic tx_done_i,
   input wire logic tx_start_o,
   input wire logic rx_irq_request_o,
   input wire logic tx_irq_request_o,
   input wire logic [5:0] serial_status_reg_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   logic [5:0] s;
   logic acc;
   assign s = serial_status_reg_o;
   assign acc = psel && penable && !pready;
   a_err_rise: assert property (
      |(s[1:0] & ~$past(s[1:0])) |-> $past(rx_done_i && s[3:2] == 2'h0))
      else $error("error flag set without a kept word");
   a_overrun_flag_rise: assert property (
      $rose(s[2]) |-> $past(rx_done_i && s[3]))
      else $error("overrun flag set without a full buffer");
   a_drop_quiet: assert property (
      rx_done_i && s[2] && !(acc && !pwrite && paddr == `USF_ADDR_RXBUF)
      |=> !rx_irq_request_o && $stable(s[3:0]))
      else $error("dropped word changed flags or raised irq");
   a_rx_holding_full_flag_load: assert property (
      rx_done_i && s[3:2] == 2'h0 |=> s[3] && rx_irq_request_o)
      else $error("word not loaded with irq");
   a_clear_armed: assert property (
      |(~s[3:0] & $past(s[3:0])) |->
      $past(acc && !pwrite && paddr == `USF_ADDR_RXBUF))
      else $error("rx flag cleared without buffer read");
   a_tx_begin: assert property (
      $rose(s[4]) |-> tx_start_o && tx_irq_request_o && !s[5])
      else $error("tx start without irq or with full holding");
   a_busy_end: assert property (
      $fell(s[4]) |-> $past(tx_done_i && !s[5]))
      else $error("busy cleared with word waiting");
   a_tx_holding_full_flag_set: assert property (
      $rose(s[5]) |-> $past(acc && pwrite && paddr == `USF_ADDR_TXBUF))
      else $error("tx full set without holding write");
   cover property (rx_done_i && s[2]);
   cover property ($fell(s[4]));
   cover property ($fell(s[2]));
endmodule // usf_flags_checker
bind usf_flags usf_flags_checker chk_i (
   .clk_sys_i(clk_sys_i),
   .resetn_i(resetn_i),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pready(pready),
   .rx_done_i(rx_done_i),
   .tx_done_i(tx_done_i),
   .tx_start_o(tx_start_o),
   .rx_irq_request_o(rx_irq_request_o),
   .tx_irq_request_o(tx_irq_request_o),
   .serial_status_reg_o(serial_status_reg_o)
);
`default_nettype wire

/* dv/usf_peer.sv */
`timescale 1ns/10ps
`default_nettype none
module usf_peer (
   input wire logic clk_sys_i,
   input wire logic start_i,
   input wire logic [7:0] word_i,
   output logic line_o,
   output logic smp_o,
   output logic done_o,
   output logic [7:0] data_o,
   output logic pbad_o,
   output logic txd_o,
   output logic [7:0] got_o
);
   initial begin
      {line_o, smp_o, done_o, data_o, pbad_o, txd_o, got_o} = 21'h100000;
      forever begin
         @(posedge clk_sys_i);
         if (start_i === 1'b1) begin
            got_o <= word_i;
            repeat (20) @(posedge clk_sys_i);
            txd_o <= 1'b1;
            @(posedge clk_sys_i);
            txd_o <= 1'b0;
         end
      end
   end
   // Stop bit level held through three mid-bit ticks, then word done
   task automatic send(input logic [7:0] d, input logic pb, input logic sb);
      {data_o, pbad_o, line_o} <= {d, pb, sb};
      repeat (5) @(posedge clk_sys_i);
      repeat (3) begin
         smp_o <= 1'b1;
         @(posedge clk_sys_i);
         smp_o <= 1'b0;
         @(posedge clk_sys_i);
      end
      done_o <= 1'b1;
      @(posedge clk_sys_i);
      {done_o, data_o, pbad_o, line_o} <= {1'b0, ~d, ~pb, 1'b1};
      @(posedge clk_sys_i);
   endtask
endmodule // usf_peer
`default_nettype wire

/* dv/usf_flags_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "usf_consts.svh"
module usf_flags_tb_top;
   import usf_pkg::*;
   logic clk_sys_i = 1'b0, resetn_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic serial_rx_line_i, sample_en_i, rx_done_i, rx_parity_bad_i;
   logic tx_done_i, tx_start_o, rx_irq_request_o, tx_irq_request_o, irq_o;
   logic [7:0] rx_data_i, tx_word_o, got;
   logic [5:0] serial_status_reg_o;
   int bad_count = 0, checked = 0, cyc = 0;
   usf_flags dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_rx_line_i(serial_rx_line_i), .sample_en_i(sample_en_i),
      .rx_done_i(rx_done_i), .rx_data_i(rx_data_i),
      .rx_parity_bad_i(rx_parity_bad_i), .tx_done_i(tx_done_i),
      .tx_start_o(tx_start_o), .tx_word_o(tx_word_o),
      .rx_irq_request_o(rx_irq_request_o),
      .tx_irq_request_o(tx_irq_request_o), .irq_o(irq_o),
      .serial_status_reg_o(serial_status_reg_o));
   usf_peer peer (.clk_sys_i(clk_sys_i), .start_i(tx_start_o),
      .word_i(tx_word_o), .line_o(serial_rx_line_i), .smp_o(sample_en_i),
      .done_o(rx_done_i), .data_o(rx_data_i), .pbad_o(rx_parity_bad_i),
      .txd_o(tx_done_i), .got_o(got));
   initial forever #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
      @(posedge clk_sys_i);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   initial begin
      repeat (20) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      @(posedge clk_sys_i);
      rchk(`USF_ADDR_STATUS, 32'h0);
      apb(1'b1, `USF_ADDR_IRQ_EN, 32'h3);
      peer.send(8'hA5, 1'b0, 1'b1);
      chk(irq_o, 32'h1);
      rchk(`USF_ADDR_STATUS, 32'h08);
      rchk(`USF_ADDR_RXBUF, 32'hA5);
      rchk(`USF_ADDR_STATUS, 32'h0);
      apb(1'b1, `USF_ADDR_IRQ_CLR, 32'h3);
      chk(irq_o, 32'h0);
      $display("test rx_basic done");
      apb(1'b1, `USF_ADDR_IRQ_EN, 32'h2);
      peer.send(8'h3C, 1'b1, 1'b0);
      chk(irq_o, 32'h0);
      rchk(`USF_ADDR_IRQ_STAT, 32'h1);
      rchk(`USF_ADDR_STATUS, 32'h0B);
      rchk(`USF_ADDR_RXBUF, 32'h3C);
      rchk(`USF_ADDR_STATUS, 32'h0);
      $display("test rx_errors done");
      peer.send(8'h11, 1'b0, 1'b1);
      rchk(`USF_ADDR_STATUS, 32'h08);
      peer.send(8'h22, 1'b1, 1'b0);
      rchk(`USF_ADDR_RXBUF, 32'h11);
      rchk(`USF_ADDR_STATUS, 32'h04);
      apb(1'b1, `USF_ADDR_IRQ_CLR, 32'h3);
      peer.send(8'h33, 1'b0, 1'b1);
      rchk(`USF_ADDR_IRQ_STAT, 32'h0);
      rchk(`USF_ADDR_STATUS, 32'h04);
      rchk(`USF_ADDR_RXBUF, 32'h11);
      rchk(`USF_ADDR_STATUS, 32'h0);
      $display("test overrun done");
      apb(1'b1, `USF_ADDR_TXBUF, 32'h5A);
      rchk(`USF_ADDR_STATUS, 32'h10);
      chk(got, 32'h5A);
      apb(1'b1, `USF_ADDR_TXBUF, 32'hC3);
      rchk(`USF_ADDR_STATUS, 32'h30);
      repeat (20) @(posedge clk_sys_i);
      chk(got, 32'hC3);
      rchk(`USF_ADDR_STATUS, 32'h10);
      repeat (30) @(posedge clk_sys_i);
      rchk(`USF_ADDR_STATUS, 32'h0);
      rchk(`USF_ADDR_IRQ_STAT, 32'h2);
      apb(1'b0, 12'h020, 32'h0);
      chk(err, 32'h1);
      $display("test tx_and_bus done");
      wrap_up();
   end
endmodule // usf_flags_tb_top
`default_nettype wire
